// file: irtl_params.svh
`ifndef IRTL_PARAMS_SVH
`define IRTL_PARAMS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define IRTL_CLK_HZ 25000000
`define IRTL_TICK_US 1
`define IRTL_TICK_CYC ((`IRTL_CLK_HZ / 1000000) * `IRTL_TICK_US)
// ----------------------------------------
// descriptor layout
// ----------------------------------------
`define IRTL_DUR_W 15
`define IRTL_DESC_W 16
`define IRTL_DESC_STATE_BIT 15
`define IRTL_DUR_MAX 16'h7FFF
`define IRTL_FIFO_DEPTH 16
`define IRTL_FIFO_AW 4
// ----------------------------------------
// learning
// ----------------------------------------
`define IRTL_CAR_W 16
`define IRTL_GAP_US 16'h0064
`define IRTL_MEAS_DEPTH 16
`define IRTL_MEAS_AW 4
`endif

// file: irtl_pkg.sv
package irtl_pkg;
   typedef enum logic [1:0] {
      IRTL_SRC_DESC,
      IRTL_SRC_BIT,
      IRTL_SRC_UART,
      IRTL_SRC_OFF
   } irtl_src_e;
   typedef enum logic [1:0] {
      IRTL_TX_IDLE,
      IRTL_TX_PLAY,
      IRTL_TX_UNDER
   } irtl_tx_e;
endpackage : irtl_pkg

// file: irtl_learn.sv
`timescale 1ns/1ns
`default_nettype none
`include "irtl_params.svh"
module irtl_learn
   import irtl_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic tick,
   input wire logic ir_in,
   input wire logic rd_pop,
   output logic meas_valid,
   output logic [`IRTL_DESC_W-1:0] meas_data,
   output logic meas_overflow,
   output logic [`IRTL_CAR_W-1:0] carrier_period,
   output logic modulated
);
   // ----------------------------------------
   // carrier detect: fast edges inside a burst
   // ----------------------------------------
   logic ir_d;
   logic present;
   logic [`IRTL_CAR_W-1:0] cyc_cnt;
   logic [15:0] gap_us;
   logic [`IRTL_DUR_W-1:0] dur_us;
   logic [`IRTL_DESC_W-1:0] mem [`IRTL_MEAS_DEPTH];
   logic [`IRTL_MEAS_AW:0] wr_ptr;
   logic [`IRTL_MEAS_AW:0] rd_ptr;
   wire rise = ir_in & ~ir_d;
   wire any_edge = ir_in ^ ir_d;
   // carrier period under 100 us => 10 kHz floor; 500 kHz is 50 cycles
   wire is_carrier = rise && (cyc_cnt < `IRTL_CAR_W'(`IRTL_TICK_CYC * 100));
   wire gap_done = ~ir_in && (gap_us >= `IRTL_GAP_US);
   wire next_present = (ir_in | (present & ~gap_done));
   wire change = next_present ^ present;
   wire full = (wr_ptr[`IRTL_MEAS_AW] != rd_ptr[`IRTL_MEAS_AW]) &&
               (wr_ptr[`IRTL_MEAS_AW-1:0] == rd_ptr[`IRTL_MEAS_AW-1:0]);
   wire empty = wr_ptr == rd_ptr;
   wire push = change && (dur_us != '0) && !full;
   wire sat = dur_us == `IRTL_DUR_W'(`IRTL_DUR_MAX);
   // absence is only known one gap after the last fall, so that gap is moved over
   wire [`IRTL_DUR_W-1:0] gap_w = `IRTL_DUR_W'(`IRTL_GAP_US);
   wire [`IRTL_DUR_W-1:0] rec_us = present ? dur_us - gap_w : dur_us;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ir_d <= 1'b0;
         cyc_cnt <= '0;
         carrier_period <= '0;
         modulated <= 1'b0;
      end else begin
         ir_d <= ir_in;
         if (rise) cyc_cnt <= '0;
         else if (cyc_cnt != '1) cyc_cnt <= cyc_cnt + 1'b1;
         if (is_carrier) begin
            carrier_period <= cyc_cnt + 1'b1;
            modulated <= 1'b1;
         end else if (rise) modulated <= 1'b0;
      end
   end

   // ----------------------------------------
   // present/absent interval timing
   // ----------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         present <= 1'b0;
         gap_us <= '0;
         dur_us <= '0;
      end else begin
         present <= next_present;
         if (any_edge) gap_us <= '0;
         else if (tick && gap_us != 16'hFFFF) gap_us <= gap_us + 1'b1;
         if (change) dur_us <= present ? gap_w : '0;
         else if (tick && !sat) dur_us <= dur_us + 1'b1;
      end
   end

   // ----------------------------------------
   // result buffer; overflow drops the interval
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (push) mem[wr_ptr[`IRTL_MEAS_AW-1:0]] <= {present, rec_us};
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         meas_overflow <= 1'b0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (rd_pop && !empty) rd_ptr <= rd_ptr + 1'b1;
         if (change && full) meas_overflow <= 1'b1;
      end
   end

   assign meas_valid = !empty;
   assign meas_data = mem[rd_ptr[`IRTL_MEAS_AW-1:0]];
endmodule : irtl_learn
`default_nettype wire

// file: irtl_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "irtl_params.svh"
//
// Contract
// - the transmitter emits plain or carrier-modulated output as configured.
// - with modulation on, the carrier is gated into every on interval.
// - the source is descriptors, a direct bit or the uart transmit line.
// - each descriptor holds a state for 1 to 32767 us before the next is taken.
// - the learner detects modulated and unmodulated input.
// - the learner measures carrier frequency from 10 kHz to 500 kHz.
// - the learner reports how long the signal stays present and absent.
// - learned timing can be replayed through the normal descriptor path.
module irtl_top
   import irtl_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [1:0] tx_src,
   input wire logic mod_en,
   input wire logic [15:0] carrier_half,
   input wire logic tx_bit,
   input wire logic uart_txd,
   input wire logic desc_valid,
   input wire logic [`IRTL_DESC_W-1:0] desc_data,
   output logic desc_ready,
   input wire logic play_start,
   output logic tx_busy,
   output logic underrun,
   input wire logic underrun_clr,
   output logic ir_out,
   input wire logic ir_in,
   input wire logic meas_pop,
   output logic meas_valid,
   output logic [`IRTL_DESC_W-1:0] meas_data,
   output logic meas_overflow,
   output logic [`IRTL_CAR_W-1:0] carrier_period,
   output logic modulated
);
   // ----------------------------------------
   // microsecond tick
   // ----------------------------------------
   logic [7:0] tick_cnt;
   logic tick;
   wire tick_wrap = tick_cnt == 8'(`IRTL_TICK_CYC - 1);
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end else begin
         tick <= tick_wrap;
         tick_cnt <= tick_wrap ? '0 : tick_cnt + 1'b1;
      end
   end

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic uart_s1, uart_s2, ir_s1, ir_s2;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         uart_s1 <= 1'b1;
         uart_s2 <= 1'b1;
         ir_s1 <= 1'b0;
         ir_s2 <= 1'b0;
      end else begin
         uart_s1 <= uart_txd;
         uart_s2 <= uart_s1;
         ir_s1 <= ir_in;
         ir_s2 <= ir_s1;
      end
   end

   // ----------------------------------------
   // descriptor fifo
   // ----------------------------------------
   logic [`IRTL_DESC_W-1:0] fifo [`IRTL_FIFO_DEPTH];
   logic [`IRTL_FIFO_AW:0] wp, rp;
   wire f_empty = wp == rp;
   // full when the wrap bits differ and the index bits agree
   function automatic logic ptr_full(input logic [`IRTL_FIFO_AW:0] a,
                                     input logic [`IRTL_FIFO_AW:0] b);
      return (a[`IRTL_FIFO_AW] != b[`IRTL_FIFO_AW]) &&
             (a[`IRTL_FIFO_AW-1:0] == b[`IRTL_FIFO_AW-1:0]);
   endfunction : ptr_full
   wire [`IRTL_FIFO_AW:0] wp_inc = wp + 1'b1;
   wire f_full = ptr_full(wp, rp);
   // zero duration is illegal and dropped at the door
   wire dur_ok = desc_data[`IRTL_DUR_W-1:0] != '0;
   wire f_push = desc_valid && desc_ready && dur_ok;
   wire [`IRTL_DESC_W-1:0] f_head = fifo[rp[`IRTL_FIFO_AW-1:0]];

   // ----------------------------------------
   // playback machine
   // ----------------------------------------
   irtl_tx_e st, next_st;
   logic [`IRTL_DUR_W-1:0] remain;
   logic seg_on;
   wire seg_end = tick && remain == `IRTL_DUR_W'(1);
   wire take = (st == IRTL_TX_IDLE && play_start && !f_empty) ||
               (st == IRTL_TX_PLAY && seg_end && !f_empty);
   wire starve = st == IRTL_TX_PLAY && seg_end && f_empty;

   always_comb begin
      next_st = st;
      unique case (st)
         IRTL_TX_IDLE: if (take) next_st = IRTL_TX_PLAY;
         IRTL_TX_PLAY: if (starve) next_st = IRTL_TX_UNDER;
         IRTL_TX_UNDER: if (play_start && !f_empty) next_st = IRTL_TX_PLAY;
      endcase
   end

   // underrun ends a sequence; restart resumes from the queue
   wire resume = st == IRTL_TX_UNDER && play_start && !f_empty;
   wire load = take || resume;

   always_ff @(posedge mclk) begin
      if (f_push) fifo[wp[`IRTL_FIFO_AW-1:0]] <= desc_data;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st <= IRTL_TX_IDLE;
         wp <= '0;
         rp <= '0;
         remain <= '0;
         seg_on <= 1'b0;
         underrun <= 1'b0;
         desc_ready <= 1'b0;
         tx_busy <= 1'b0;
      end else begin
         st <= next_st;
         // ready looks one word ahead, so a back-to-back write never overfills
         desc_ready <= !(f_full || (f_push && ptr_full(wp_inc, rp)));
         tx_busy <= next_st == IRTL_TX_PLAY;
         if (f_push) wp <= wp_inc;
         if (load) begin
            rp <= rp + 1'b1;
            remain <= f_head[`IRTL_DUR_W-1:0];
            seg_on <= f_head[`IRTL_DESC_STATE_BIT];
         end else if (tick && st == IRTL_TX_PLAY) begin
            remain <= remain - 1'b1;
         end
         if (starve) seg_on <= 1'b0;
         // set beats clear
         if (starve) underrun <= 1'b1;
         else if (underrun_clr) underrun <= 1'b0;
      end
   end

   // ----------------------------------------
   // carrier generator and output mux
   // ----------------------------------------
   logic [15:0] car_cnt;
   logic car;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         car_cnt <= '0;
         car <= 1'b0;
      end else if (car_cnt >= carrier_half) begin
         car_cnt <= '0;
         car <= ~car;
      end else begin
         car_cnt <= car_cnt + 1'b1;
      end
   end

   irtl_src_e src;
   assign src = irtl_src_e'(tx_src);
   wire desc_on = st == IRTL_TX_PLAY && seg_on;
   // uart idles high, so the led is lit on a low (space) bit
   wire raw_on = (src == IRTL_SRC_DESC) ? desc_on :
                 (src == IRTL_SRC_BIT) ? tx_bit :
                 (src == IRTL_SRC_UART) ? ~uart_s2 : 1'b0;
   wire next_ir = mod_en ? (raw_on & car) : raw_on;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) ir_out <= 1'b0;
      else ir_out <= next_ir;
   end

   // ----------------------------------------
   // learning receiver
   // ----------------------------------------
   logic lv;
   logic [`IRTL_DESC_W-1:0] ld;
   logic lo;
   logic [`IRTL_CAR_W-1:0] lp;
   logic lm;
   irtl_learn u_learn (
      .mclk(mclk),
      .rst(rst),
      .tick(tick),
      .ir_in(ir_s2),
      .rd_pop(meas_pop),
      .meas_valid(lv),
      .meas_data(ld),
      .meas_overflow(lo),
      .carrier_period(lp),
      .modulated(lm)
   );

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         meas_valid <= 1'b0;
         meas_data <= '0;
         meas_overflow <= 1'b0;
         carrier_period <= '0;
         modulated <= 1'b0;
      end else begin
         meas_valid <= lv && !meas_pop;
         meas_data <= ld;
         meas_overflow <= lo;
         carrier_period <= lp;
         modulated <= lm;
      end
   end
endmodule : irtl_top
`default_nettype wire

// file: irtl_top_properties.sv
`timescale 1ns/1ns
`default_nettype none
module irtl_top_props (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [1:0] tx_src,
   input wire logic mod_en,
   input wire logic [15:0] carrier_half,
   input wire logic tx_bit,
   input wire logic uart_txd,
   input wire logic play_start,
   input wire logic tx_busy,
   input wire logic underrun,
   input wire logic underrun_clr,
   input wire logic ir_out,
   input wire logic meas_pop,
   input wire logic meas_valid
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   src_off_a: assert property ((tx_src == 2'd3)[*3] |-> !ir_out)
      else $error("output lit with source off");
   bit_plain_a: assert property ((tx_src == 2'd1 && !mod_en && tx_bit)[*3] |-> ir_out)
      else $error("direct bit not shown");
   uart_src_a: assert property ((tx_src == 2'd2 && !mod_en && !uart_txd)[*4] |-> ir_out)
      else $error("uart low not lit");
   carrier_gate_a: assert property
      ((tx_src == 2'd1 && mod_en && tx_bit && carrier_half == 16'h0001)[*8]
      |-> ir_out != $past(ir_out, 2))
      else $error("carrier not gated in");
   idle_dark_a: assert property ((tx_src == 2'd0 && !tx_busy)[*3] |-> !ir_out)
      else $error("lit while not playing");
   under_hold_a: assert property (underrun && !underrun_clr |=> underrun)
      else $error("underrun flag lost");
   busy_start_a: assert property ($rose(tx_busy) |-> $past(play_start))
      else $error("play without start");
   pop_drop_a: assert property ($fell(meas_valid) |-> $past(meas_pop) || $past(meas_pop, 2))
      else $error("measurement lost without pop");
   cover property ($rose(tx_busy));
   cover property ($rose(underrun));
   cover property ($rose(meas_valid));
endmodule : irtl_top_props
bind irtl_top irtl_top_props u_props (.mclk(mclk), .rst(rst), .tx_src(tx_src), .mod_en(mod_en),
   .carrier_half(carrier_half), .tx_bit(tx_bit), .uart_txd(uart_txd), .play_start(play_start),
   .tx_busy(tx_busy), .underrun(underrun), .underrun_clr(underrun_clr), .ir_out(ir_out),
   .meas_pop(meas_pop), .meas_valid(meas_valid));
`default_nettype wire

// file: irtl_ir_far.sv
`timescale 1ns/1ns
`default_nettype none
module irtl_ir_far (
   input wire logic mclk,
   input wire logic ir_out,
   output logic ir_in,
   output logic [31:0] lit_len
);
   logic [31:0] lit_cnt;
   initial begin
      ir_in = 1'b0;
      lit_cnt = 0;
      lit_len = 0;
   end
   // led light falls straight on the photodiode, so learned timing can be replayed
   always @(posedge mclk) begin
      ir_in <= ir_out;
      lit_cnt <= ir_out ? lit_cnt + 1 : 0;
      if (!ir_out && lit_cnt != 0) begin
         lit_len <= lit_cnt;
      end
   end
endmodule : irtl_ir_far
`default_nettype wire

// file: irtl_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module irtl_top_tb;
   import irtl_pkg::*;
   logic mclk, rst, mod_en, tx_bit, uart_txd, desc_valid, play_start, underrun_clr, meas_pop;
   logic [1:0] tx_src;
   logic [15:0] carrier_half, desc_data, meas_data, carrier_period;
   logic desc_ready, tx_busy, underrun, ir_out, ir_in, meas_valid, meas_overflow, modulated;
   logic [31:0] lit_len;
   int n_errors = 0, check_count = 0, d[3], tg, got;
   logic p;
   irtl_top dut (.mclk(mclk), .rst(rst), .tx_src(tx_src), .mod_en(mod_en),
      .carrier_half(carrier_half), .tx_bit(tx_bit), .uart_txd(uart_txd),
      .desc_valid(desc_valid), .desc_data(desc_data), .desc_ready(desc_ready),
      .play_start(play_start), .tx_busy(tx_busy), .underrun(underrun),
      .underrun_clr(underrun_clr), .ir_out(ir_out), .ir_in(ir_in), .meas_pop(meas_pop),
      .meas_valid(meas_valid), .meas_data(meas_data), .meas_overflow(meas_overflow),
      .carrier_period(carrier_period), .modulated(modulated));
   irtl_ir_far far (.mclk(mclk), .ir_out(ir_out), .ir_in(ir_in), .lit_len(lit_len));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s exp %h seen %h", what, exp, seen);
      end
   endtask : check
   function automatic int car_period(input int half);
      return 2 * (half + 1);
   endfunction : car_period
   // first tick phase is unknown, so an on time may come up to 1 us short
   function automatic bit on_ok(input logic [31:0] len, input int us);
      return len > (us - 1) * 25 && len <= us * 25;
   endfunction : on_ok
   // valid stays up between words, the caller drops it
   task push(input logic [15:0] w);
      desc_valid <= 1'b1;
      desc_data <= w;
      @(posedge mclk);
      while (!desc_ready) @(posedge mclk);
   endtask : push
   // valid and data show the next word two edges after the pop
   task pop;
      meas_pop <= 1'b1;
      @(posedge mclk);
      meas_pop <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask : pop
   task end_of_test;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_of_test
   initial begin
      mclk = 0;
      forever #20 mclk = ~mclk;
   end
   initial begin
      repeat (40000) @(posedge mclk);
      n_errors++;
      end_of_test();
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      {rst, tx_src} = 3'b111;
      {mod_en, tx_bit, desc_valid, play_start, underrun_clr, meas_pop} = 0;
      uart_txd = 1;
      carrier_half = 0;
      desc_data = 0;
      void'($urandom(43375));
      repeat (5) @(posedge mclk);
      rst <= 0;
      repeat (2) @(posedge mclk);
      tx_src <= 2'd0;
      push(16'h0000);
      for (int i = 0; i < 3; i++) begin
         d[i] = $urandom_range(6, 2);
         push({1'b1, 15'(d[i])});
         push(16'h0001);
      end
      desc_valid <= 1'b0;
      play_start <= 1'b1;
      @(posedge mclk);
      play_start <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         @(negedge ir_out);
         @(posedge mclk);
         #1 check("on time", on_ok(lit_len, d[i]), 1);
         check("busy", tx_busy, 1);
      end
      @(posedge underrun);
      repeat (3) @(posedge mclk);
      check("underrun", {underrun, ir_out, tx_busy}, 3'b100);
      underrun_clr <= 1'b1;
      @(posedge mclk);
      underrun_clr <= 1'b0;
      @(posedge mclk);
      check("underrun clr", underrun, 0);
      $display("descriptor test done");
      tx_src <= 2'd1;
      for (int k = 0; k < 4; k++) begin
         tx_bit <= 1'($urandom);
         repeat (3) @(posedge mclk);
         check("bit out", ir_out, tx_bit);
      end
      tx_src <= 2'd2;
      uart_txd <= 1'b0;
      repeat (4) @(posedge mclk);
      check("uart out", ir_out, 1);
      mod_en <= 1'b1;
      carrier_half <= 16'h0001;
      tx_src <= 2'd1;
      tx_bit <= 1'b1;
      repeat (6) @(posedge mclk);
      tg = 0;
      repeat (20) begin
         p = ir_out;
         @(posedge mclk);
         if (ir_out !== p) tg++;
      end
      check("carrier edges", tg, 40 / car_period(1));
      $display("source test done");
      {mod_en, tx_bit} <= 2'b00;
      repeat (3000) @(posedge mclk);
      while (meas_valid) pop();
      tx_bit <= 1'b1;
      repeat (250) @(posedge mclk);
      tx_bit <= 1'b0;
      repeat (3000) @(posedge mclk);
      got = 0;
      while (meas_valid) begin
         if (meas_data[15] && got == 0) begin
            got = 1;
            check("present us", meas_data[14:0] >= 9 && meas_data[14:0] <= 11, 1);
            d[0] = int'(meas_data[14:0]);
         end
         pop();
      end
      check("present seen", got, 1);
      check("plain input", modulated, 0);
      tx_src <= 2'd0;
      push({1'b1, 15'(d[0])});
      desc_valid <= 1'b0;
      play_start <= 1'b1;
      @(posedge mclk);
      play_start <= 1'b0;
      @(negedge ir_out);
      repeat (2) @(posedge mclk);
      check("replay", on_ok(lit_len, d[0]), 1);
      {tx_src, mod_en, tx_bit} <= 4'b0111;
      carrier_half <= 16'h0018;
      repeat (500) @(posedge mclk);
      tx_bit <= 1'b0;
      repeat (3000) @(posedge mclk);
      check("modulated", modulated, 1);
      check("carrier period", carrier_period, car_period(24));
      check("overflow", meas_overflow, 0);
      $display("learning test done");
      end_of_test();
   end
endmodule : irtl_top_tb
`default_nettype wire
